// *** hw/hbr_regs_pkg.sv ***
/*
 * Package for the H-bridge driver register bank: register addresses, field
 * positions, reset values and the packed carriers for frames and status.
 * Assumes a single synchronous clock domain and a word-level frame port.
 */
package hbr_regs_pkg;

    localparam logic [4:0] ADDR_FAULT_SUMMARY = 5'h00;
    localparam logic [4:0] ADDR_BRIDGE_DIAG = 5'h01;
    localparam logic [4:0] ADDR_DRIVE_CFG = 5'h02;
    localparam logic [4:0] ADDR_PROTECT_CFG = 5'h03;
    localparam logic [4:0] ADDR_CMD_OUT_CTRL = 5'h04;
    localparam logic [4:0] ADDR_OPENLOAD_CFG = 5'h05;

    // Request word field positions.
    localparam int REQ_READ_BIT = 14;
    localparam int REQ_ADDR_HI = 13;
    localparam int REQ_ADDR_LO = 9;

    // Fault summary field positions.
    localparam int FS_GLOBAL_BIT = 6;

    // Command and output control field positions.
    localparam int CMD_CLEAR_BIT = 7;
    localparam int CMD_LOCK_HI = 6;
    localparam int CMD_LOCK_LO = 4;

    localparam logic [2:0] LOCK_ENGAGE = 3'h3;
    localparam logic [2:0] LOCK_RELEASE = 3'h4;

    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] DRIVE_CFG_RESET = 8'h51;
    localparam logic [7:0] PROTECT_CFG_RESET = 8'h0C;
    localparam logic [7:0] CMD_OUT_CTRL_RESET = 8'h40;
    localparam logic [7:0] OPENLOAD_CFG_RESET = 8'h00;
    localparam logic [1:0] RESP_STATUS_TOP = 2'h3;

    // Raw condition inputs from the protection circuits.
    typedef struct packed {
        logic overtemp_warning;
        logic supply_undervoltage;
        logic charge_pump_undervoltage;
        logic thermal_shutdown;
        logic open_load_hb1;
        logic open_load_hb2;
        logic current_regulating_hb1;
        logic current_regulating_hb2;
        logic overcurrent_high_fet_hb1;
        logic overcurrent_low_fet_hb1;
        logic overcurrent_high_fet_hb2;
        logic overcurrent_low_fet_hb2;
    } hbr_events_t;

    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } hbr_frame_t;

    typedef enum logic [1:0] {
        HBR_IDLE = 2'b00,
        HBR_EXEC = 2'b01,
        HBR_ANSWER = 2'b11
    } hbr_state_t;

endpackage

// *** hw/hbr_regs.sv ***
/*
 * Register bank of the H-bridge driver. Takes one received 16-bit request
 * word per valid pulse and returns a 16-bit answer word.
 * Assumes the frame shifter outside delivers only complete, well-formed
 * frames and that event inputs are synchronous to mclk.
 */
// How it works
// - Fault and diagnostic registers ignore host writes.
// - Bit six is complement of fault pin.
// - Fault summary bits five down to zero.
// - Diagnostic bits seven, six flag open load.
// - Diagnostic bits five, four show current regulation.
// - Diagnostic bits three to zero flag overcurrent.
// - Status registers reset to zero.
// - Addresses two through five read and write.
// - Drive configuration field layout held as written.
// - Protection configuration field layout held as written.
// - Command register holds lock, disables, drives; clear bit not stored.
// - Fault clear wipes flags, self-resets.
// - Lock code freezes drive configuration.
// - Request word: read bit, address, data.
// - Answer word: status byte, then register.
module hbr_regs
    import hbr_regs_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Request and answer words
    input hbr_frame_t req,
    output hbr_frame_t resp,
    // Protection conditions
    input hbr_events_t events,
    // Configuration outputs to the bridge logic, and the fault pin
    output logic [7:0] drive_cfg,
    output logic [7:0] protect_cfg,
    output logic [7:0] cmd_out_ctrl,
    output logic [7:0] openload_cfg,
    output logic fault_pin_n
);

    hbr_state_t state_r;
    logic [15:0] word_r;
    logic [7:0] fault_r;
    logic [7:0] diag_r;
    logic [7:0] drive_r;
    logic [7:0] protect_r;
    logic [7:0] cmd_r;
    logic [7:0] openload_r;
    logic fault_pin_n_r;
    logic locked_r;
    logic clear_now;
    logic wr_en;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic [7:0] fault_nxt;
    logic [7:0] diag_nxt;
    logic any_fault;

    function automatic logic [7:0] read_reg(input logic [4:0] a, input logic [7:0] f,
        input logic [7:0] d, input logic [7:0] c2, input logic [7:0] c3,
        input logic [7:0] c4, input logic [7:0] c5);
        case (a)
            ADDR_FAULT_SUMMARY: read_reg = f;
            ADDR_BRIDGE_DIAG: read_reg = d;
            ADDR_DRIVE_CFG: read_reg = c2;
            ADDR_PROTECT_CFG: read_reg = c3;
            ADDR_CMD_OUT_CTRL: read_reg = c4;
            ADDR_OPENLOAD_CFG: read_reg = c5;
            default: read_reg = 8'h00;
        endcase
    endfunction

    assign addr = word_r[REQ_ADDR_HI:REQ_ADDR_LO];
    assign wdata = word_r[7:0];
    assign wr_en = (state_r == HBR_EXEC) && !word_r[REQ_READ_BIT];
    assign clear_now = wr_en && (addr == ADDR_CMD_OUT_CTRL) && wdata[CMD_CLEAR_BIT];

    // Status flags other than regulation and the global bit six are sticky: a set in the clear cycle wins over the clear.
    always_comb
    begin
        fault_nxt = fault_r;
        diag_nxt = diag_r;
        if (clear_now)
        begin
            fault_nxt = STATUS_RESET;
            diag_nxt = STATUS_RESET;
        end
        fault_nxt[5] = fault_nxt[5] | events.overtemp_warning;
        fault_nxt[4] = fault_nxt[4] | events.supply_undervoltage;
        fault_nxt[3] = fault_nxt[3] | events.charge_pump_undervoltage;
        fault_nxt[1] = fault_nxt[1] | events.thermal_shutdown;
        diag_nxt[7] = diag_nxt[7] | events.open_load_hb1;
        diag_nxt[6] = diag_nxt[6] | events.open_load_hb2;
        // Regulation is a live level, never latched.
        diag_nxt[5] = events.current_regulating_hb1;
        diag_nxt[4] = events.current_regulating_hb2;
        diag_nxt[3] = diag_nxt[3] | events.overcurrent_high_fet_hb1;
        diag_nxt[2] = diag_nxt[2] | events.overcurrent_low_fet_hb1;
        diag_nxt[1] = diag_nxt[1] | events.overcurrent_high_fet_hb2;
        diag_nxt[0] = diag_nxt[0] | events.overcurrent_low_fet_hb2;
        fault_nxt[2] = |diag_nxt[3:0];
        fault_nxt[0] = |diag_nxt[7:6];
        fault_nxt[7] = 1'b0;
        any_fault = |fault_nxt[4:0] | (fault_nxt[5] & protect_r[5])
            | (|diag_nxt[5:4] & protect_r[7]);
        fault_nxt[FS_GLOBAL_BIT] = any_fault;
    end

    // Status registers take no host write data; only a command write's clear bit wipes them.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            fault_r <= STATUS_RESET;
            diag_r <= STATUS_RESET;
            fault_pin_n_r <= 1'b1;
        end
        else
        begin
            fault_r <= fault_nxt;
            diag_r <= diag_nxt;
            fault_pin_n_r <= ~fault_nxt[FS_GLOBAL_BIT];
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r <= HBR_IDLE;
            word_r <= 16'h0000;
        end
        else
        begin
            case (state_r)
                HBR_IDLE:
                begin
                    if (req.valid)
                    begin
                        word_r <= req.word;
                        state_r <= HBR_EXEC;
                    end
                end
                HBR_EXEC: state_r <= HBR_ANSWER;
                HBR_ANSWER: state_r <= HBR_IDLE;
                default: state_r <= HBR_IDLE;
            endcase
        end
    end

    // Configuration writes; unmapped and status addresses fall through.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            drive_r <= DRIVE_CFG_RESET;
            protect_r <= PROTECT_CFG_RESET;
            cmd_r <= CMD_OUT_CTRL_RESET;
            openload_r <= OPENLOAD_CFG_RESET;
            locked_r <= 1'b0;
        end
        else if (wr_en)
        begin
            case (addr)
                ADDR_DRIVE_CFG:
                begin
                    if (!locked_r)
                        drive_r <= wdata;
                end
                ADDR_PROTECT_CFG: protect_r <= wdata;
                ADDR_CMD_OUT_CTRL:
                begin
                    cmd_r <= {1'b0, wdata[6:0]};
                    if (wdata[CMD_LOCK_HI:CMD_LOCK_LO] == LOCK_ENGAGE)
                        locked_r <= 1'b1;
                    else if (wdata[CMD_LOCK_HI:CMD_LOCK_LO] == LOCK_RELEASE)
                        locked_r <= 1'b0;
                end
                ADDR_OPENLOAD_CFG: openload_r <= wdata;
                default: ;
            endcase
        end
    end

    // Answer carries the contents as they stood before the write.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            resp <= '0;
        else if (state_r == HBR_EXEC)
        begin
            resp.valid <= 1'b1;
            resp.word <= {RESP_STATUS_TOP, fault_r[5:0],
                read_reg(addr, fault_r, diag_r, drive_r, protect_r, cmd_r,
                openload_r)};
        end
        else
            resp.valid <= 1'b0;
    end

    assign drive_cfg = drive_r;
    assign protect_cfg = protect_r;
    assign cmd_out_ctrl = cmd_r;
    assign openload_cfg = openload_r;
    assign fault_pin_n = fault_pin_n_r;

    AST_STATUS_RO: assert property (@(posedge mclk) disable iff (!nrst)
        (wr_en && addr <= ADDR_BRIDGE_DIAG && !clear_now && events == '0
        && !diag_r[5] && !diag_r[4]) |=> (fault_r == $past(fault_r)))
        else $error("status changed by host write");
    AST_GLOBAL_PIN: assert property (@(posedge mclk) disable iff (!nrst)
        fault_r[FS_GLOBAL_BIT] == ~fault_pin_n)
        else $error("global fault bit disagrees with pin");
    AST_RESERVED_BIT_ZERO: assert property (@(posedge mclk) disable iff (!nrst)
        !fault_r[7] && (fault_r[2] == |diag_r[3:0]))
        else $error("fault summary layout wrong");
    AST_OPENLOAD: assert property (@(posedge mclk) disable iff (!nrst)
        events.open_load_hb1 |=> diag_r[7])
        else $error("open load hb1 not flagged");
    AST_REGULATION: assert property (@(posedge mclk) disable iff (!nrst)
        ##1 diag_r[5] == $past(events.current_regulating_hb1))
        else $error("regulation bit does not follow");
    AST_OVERCURRENT: assert property (@(posedge mclk) disable iff (!nrst)
        events.overcurrent_low_fet_hb2 |=> diag_r[0] && fault_r[2])
        else $error("overcurrent not flagged");
    AST_CLEAR_SELF: assert property (@(posedge mclk) disable iff (!nrst)
        clear_now |=> !cmd_r[CMD_CLEAR_BIT] && (events != '0 || !fault_r[3]))
        else $error("fault clear failed");
    AST_LOCK_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
        (locked_r && wr_en && addr == ADDR_DRIVE_CFG) |=> $stable(drive_r))
        else $error("locked drive configuration changed");
    AST_ANSWER_TIME: assert property (@(posedge mclk) disable iff (!nrst)
        (state_r == HBR_IDLE && req.valid) |-> ##2 resp.valid
        && resp.word[15:14] == RESP_STATUS_TOP)
        else $error("answer late or malformed");
    AST_RESERVED_WR: assert property (@(posedge mclk) disable iff (!nrst)
        (wr_en && addr > ADDR_OPENLOAD_CFG) |=> $stable(drive_r) && $stable(cmd_r))
        else $error("reserved write changed state");

endmodule

// *** sim/hbr_host.sv ***
/*
 * Host model for the H-bridge register bank: sends whole request words and
 * collects the answer word. Assumes the frame shifter is abstracted away.
 */
module hbr_host
    import hbr_regs_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Request and answer words
    output hbr_frame_t req,
    input hbr_frame_t resp
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req = '0;

    // The word is inverted once released so a stale request never matches.
    task automatic xfer(input logic [15:0] w, output logic [15:0] a);
        int n;
        @(posedge mclk);
        req <= '{valid: 1'b1, word: w};
        @(posedge mclk);
        req <= '{valid: 1'b0, word: ~w};
        for (n = 0; n < 8; n++)
        begin
            @(posedge mclk);
            #1;
            if (resp.valid === 1'b1)
                break;
        end
        // A missing answer becomes unknown so that the compare cannot pass it.
        a = (resp.valid === 1'b1) ? resp.word : 'x;
    endtask
endmodule

// *** sim/hbr_regs_test.sv ***
/*
 * Self-checking bench for the H-bridge register bank with a reference model.
 * Assumes the host model in hbr_host drives all request words.
 */
module hbr_regs_test;
    import hbr_regs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0;
    logic nrst = 1'b0;
    hbr_frame_t req;
    hbr_frame_t resp;
    hbr_events_t events = '0;
    logic [7:0] c2, c3, c4, c5;
    logic fpn;
    int n_fail = 0;
    int num_checks = 0;
    int seed = 32'h8446;
    logic [7:0] fs = 8'h00;
    logic [7:0] dg = 8'h00;
    logic [7:0] cf [2:5];
    logic lk = 1'b0;

    always #2 mclk = ~mclk;

    hbr_regs uut (.mclk(mclk), .nrst(nrst), .req(req), .resp(resp), .events(events),
        .drive_cfg(c2), .protect_cfg(c3), .cmd_out_ctrl(c4), .openload_cfg(c5),
        .fault_pin_n(fpn));
    hbr_host host (.mclk(mclk), .req(req), .resp(resp));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
        num_checks++;
        if ((got & m) !== (exp & m))
        begin
            n_fail++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Folds the present conditions into the sticky flags and live regulation bits of the model.
    task automatic evin();
        logic [11:0] v;
        v = events;
        dg[7:6] = dg[7:6] | v[7:6];
        dg[5:4] = v[5:4];
        dg[3:0] = dg[3:0] | v[3:0];
        fs[5:3] = fs[5:3] | v[11:9];
        fs[2] = fs[2] | (|v[3:0]);
        fs[1] = fs[1] | v[8];
        fs[0] = fs[0] | (|v[7:6]);
        fs[6] = (|fs[4:0]) | (fs[5] & cf[3][5]) | ((|dg[5:4]) & cf[3][7]);
    endtask

    task automatic op(input logic [15:0] w);
        logic [15:0] a, e, m;
        logic [7:0] d;
        d = w[7:0];
        m = 16'hFFFF;
        evin();
        case (w[13:9])
            5'h00: e[7:0] = fs;
            5'h01: e[7:0] = dg;
            5'h02, 5'h03, 5'h04, 5'h05: e[7:0] = cf[w[11:9]];
            default: e[7:0] = 8'h00;
        endcase
        e[15:8] = {RESP_STATUS_TOP, fs[5:0]};
        if (w[14] == 1'b0)
        begin
            case (w[13:9])
                5'h02: if (!lk) cf[2] = d;
                5'h03: cf[3] = d;
                5'h04:
                begin
                    cf[4] = {1'b0, d[6:0]};
                    if (d[6:4] == LOCK_ENGAGE) lk = 1'b1;
                    if (d[6:4] == LOCK_RELEASE) lk = 1'b0;
                    if (d[7])
                    begin
                        fs = 8'h00;
                        dg = 8'h00;
                        m = 16'h00FF;
                    end
                end
                5'h05: cf[5] = d;
                default: ;
            endcase
            evin();
        end
        host.xfer(w, a);
        chk(a, e, m);
        @(posedge mclk);
        #1;
        chk({15'h0, fpn}, {15'h0, ~fs[6]}, 16'h0001);
        chk({c2, c3}, {cf[2], cf[3]}, 16'hFFFF);
        chk({c4, c5}, {cf[4], cf[5]}, 16'hFFFF);
    endtask

    task automatic ev_set(input logic [11:0] v);
        @(posedge mclk);
        events <= v;
        repeat (2) @(posedge mclk);
    endtask

    task automatic complete_run();
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        #100000;
        n_fail++;
        complete_run();
    end

    initial
    begin
        logic [15:0] w;
        cf[2] = DRIVE_CFG_RESET;
        cf[3] = PROTECT_CFG_RESET;
        cf[4] = CMD_OUT_CTRL_RESET;
        cf[5] = OPENLOAD_CFG_RESET;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        for (int i = 0; i < 8; i++)
            op({2'b01, i[4:0], 9'h000});
        op(16'h7E00);
        ev_set(12'hFFF);
        op(16'h4000);
        op(16'h4200);
        ev_set(12'h000);
        op(16'h4200);
        op(16'h0880);
        op(16'h4000);
        op(16'h00FF);
        op(16'h02FF);
        op(16'h4000);
        ev_set(12'h0A5);
        op(16'h00FF);
        op(16'h02FF);
        op(16'h0CFF);
        op(16'h4C00);
        op(16'h0830);
        op(16'h04A5);
        op(16'h4400);
        op(16'h0840);
        op(16'h04A5);
        repeat (60)
        begin
            ev_set(12'($random(seed)));
            w = 16'($random(seed));
            w[15] = 1'b0;
            w[13:12] = 2'b00;
            // Random writes stay inside the map; reserved writes are tested above.
            if (!w[14] && w[11:10] == 2'b11) w[11] = 1'b0;
            op(w);
        end
        complete_run();
    end
endmodule
